// ==== core/mre_pkg.sv ====
// constants shared by the move-and-return execution block and its return stack
package mre_pkg;
   localparam int          ACC_W        = 8;
   localparam int          FILE_ADDR_W  = 7;
   localparam int          PC_W         = 13;
   localparam int          INSTR_W      = 14;
   localparam int          STACK_DEPTH  = 8;
   localparam int          STACK_PTR_W  = 3;
   localparam int          GIE_BIT      = 7;

   localparam logic [7:0]  ACC_RESET    = 8'h00;
   localparam logic [12:0] PC_RESET     = 13'h0000;
   localparam logic [12:0] PC_STEP      = 13'h0001;
   localparam logic        GIE_RESET    = 1'b0;
   localparam logic [2:0]  PTR_RESET    = 3'h0;
   localparam logic [2:0]  PTR_STEP     = 3'h1;
   localparam logic        READY_RESET  = 1'b1;
   localparam logic        FILE_WR_RESET = 1'b0;
   localparam logic [6:0]  FILE_ADDR_RESET = 7'h00;

   // opcode patterns: a word matches when (word & mask) == pattern
   localparam logic [13:0] MASK_FULL    = 14'h3fff;
   localparam logic [13:0] MASK_COPY    = 14'h3f80;
   localparam logic [13:0] OP_COPY      = 14'h0080;
   localparam logic [13:0] MASK_LIT     = 14'h3c00;
   localparam logic [13:0] OP_LOAD_LIT  = 14'h3000;
   localparam logic [13:0] OP_RET_LIT   = 14'h3400;
   localparam logic [13:0] MASK_IDLE    = 14'h3f9f;
   localparam logic [13:0] OP_IDLE      = 14'h0000;
   localparam logic [13:0] OP_RET_INT   = 14'h0009;
   localparam logic [13:0] OP_RET_SUB   = 14'h0008;

   typedef enum logic [1:0] {
      MRE_EXEC  = 2'b01,
      MRE_FLUSH = 2'b10
   } mre_state_t;
endpackage

// ==== core/mre_stack.sv ====
// eight-entry circular hardware return stack
`timescale 1ns/1ps
`default_nettype none
module mre_stack (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        pushEn,
   input  wire logic [12:0] pushAddr,
   input  wire logic        popEn,
   output logic      [12:0] topEntry
);
   logic [12:0] mem [mre_pkg::STACK_DEPTH];
   logic [2:0]  ptr;
   logic [2:0]  next_ptr;
   logic [2:0]  topIdx;
   logic        wrEn;
   logic [2:0]  wrIdx;

   // ptr points at the next free slot; wrapping is deliberate, overflow silently overwrites the oldest
   always_comb begin
      topIdx   = ptr - mre_pkg::PTR_STEP;
      topEntry = mem[topIdx];
      next_ptr = ptr;
      wrEn     = 1'b0;
      wrIdx    = ptr;
      if (popEn && pushEn) begin
         // pop and push together replace the top entry, depth unchanged
         wrEn  = 1'b1;
         wrIdx = topIdx;
      end else if (popEn) begin
         next_ptr = topIdx;
      end else if (pushEn) begin
         wrEn     = 1'b1;
         next_ptr = ptr + mre_pkg::PTR_STEP;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ptr <= mre_pkg::PTR_RESET;
      end else begin
         ptr <= next_ptr;
      end
   end

   // entries carry no reset: contents are only meaningful after a push
   always_ff @(posedge clk_sys) begin
      if (wrEn) begin
         mem[wrIdx] <= pushAddr;
      end
   end
endmodule
`default_nettype wire

// ==== core/mre_exec.sv ====
// execution of the data-move, idle and return instruction group
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: copy_acc_to_file writes accumulator to 7-bit file address, one cycle, no flags.
// RQ2: load_literal_to_acc loads the 8-bit literal into accumulator, one cycle, no flags.
// RQ3: return_from_interrupt_op pops stack, PC gets stack_top_entry, two cycles, no flags.
// RQ4: return_from_interrupt_op also sets global_interrupt_enable, bit 7 of interrupt_control_reg.
// RQ5: return_with_literal_op loads literal into accumulator and PC from popped top, two cycles.
// RQ6: subroutine return pops stack, PC gets stack_top_entry, two cycles, no flags.
// RQ7: idle_instruction takes one cycle and changes nothing except the PC advance.
module mre_exec (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        instrValid,
   input  wire logic [13:0] instrWord,
   input  wire logic        pushEn,
   input  wire logic [12:0] pushAddr,
   input  wire logic        gieClear,
   input  wire logic        intCtrlWrEn,
   input  wire logic [7:0]  intCtrlWrData,
   output logic             instrReady,
   output logic      [7:0]  acc,
   output logic      [12:0] pc,
   output logic             fileWrEn,
   output logic      [6:0]  fileAddr,
   output logic      [7:0]  fileData,
   output logic             globalIntEnable
);
   mre_pkg::mre_state_t state;
   mre_pkg::mre_state_t next_state;
   logic        next_instrReady;
   logic [7:0]  next_acc;
   logic [12:0] next_pc;
   logic        next_fileWrEn;
   logic [6:0]  next_fileAddr;
   logic [7:0]  next_fileData;
   logic        next_globalIntEnable;

   logic        take;
   logic        isCopy;
   logic        isLoadLit;
   logic        isRetLit;
   logic        isIdle;
   logic        isRetInt;
   logic        isRetSub;
   logic        popEn;
   logic [12:0] topEntry;

   mre_stack u_stack (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pushEn   (pushEn),
      .pushAddr (pushAddr),
      .popEn    (popEn),
      .topEntry (topEntry)
   );

   // decode
   always_comb begin
      take      = instrValid && (state == mre_pkg::MRE_EXEC);
      isCopy    = (instrWord & mre_pkg::MASK_COPY) == mre_pkg::OP_COPY;
      isLoadLit = (instrWord & mre_pkg::MASK_LIT) == mre_pkg::OP_LOAD_LIT;
      isRetLit  = (instrWord & mre_pkg::MASK_LIT) == mre_pkg::OP_RET_LIT;
      isIdle    = (instrWord & mre_pkg::MASK_IDLE) == mre_pkg::OP_IDLE;
      isRetInt  = (instrWord & mre_pkg::MASK_FULL) == mre_pkg::OP_RET_INT;
      isRetSub  = (instrWord & mre_pkg::MASK_FULL) == mre_pkg::OP_RET_SUB;
      popEn     = take && (isRetInt || isRetLit || isRetSub); // see RQ3 see RQ5 see RQ6
   end

   // sequencing: a return spends its second cycle in flush, where no word is taken
   always_comb begin
      next_state = state;
      case (state)
         mre_pkg::MRE_EXEC: begin
            if (popEn) begin
               next_state = mre_pkg::MRE_FLUSH; // see RQ3 see RQ5 see RQ6
            end
         end
         mre_pkg::MRE_FLUSH: begin
            next_state = mre_pkg::MRE_EXEC;
         end
         default: begin
            next_state = mre_pkg::MRE_EXEC;
         end
      endcase
      next_instrReady = (next_state == mre_pkg::MRE_EXEC);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state      <= mre_pkg::MRE_EXEC;
         instrReady <= mre_pkg::READY_RESET;
      end else begin
         state      <= next_state;
         instrReady <= next_instrReady;
      end
   end

   // accumulator: only the two literal instructions write it
   always_comb begin
      next_acc = acc;
      if (take && isRetLit) begin
         next_acc = instrWord[7:0]; // see RQ5
      end else if (take && isLoadLit) begin
         next_acc = instrWord[7:0]; // see RQ2
      end else if (take && isIdle) begin
         next_acc = acc; // see RQ7
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         acc <= mre_pkg::ACC_RESET;
      end else begin
         acc <= next_acc;
      end
   end

   // program counter: a return jumps; any other taken word, even one outside this group, steps by one
   always_comb begin
      next_pc = pc;
      if (popEn) begin
         next_pc = topEntry; // see RQ3 see RQ6
      end else if (take) begin
         next_pc = pc + mre_pkg::PC_STEP; // see RQ7
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pc <= mre_pkg::PC_RESET;
      end else begin
         pc <= next_pc;
      end
   end

   // file write port: address and data hold between writes, only the one-cycle strobe marks a new one
   always_comb begin
      next_fileWrEn = 1'b0;
      next_fileAddr = fileAddr;
      next_fileData = fileData;
      if (take && isCopy) begin
         next_fileWrEn = 1'b1; // see RQ1
         next_fileAddr = instrWord[6:0];
         next_fileData = acc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fileWrEn <= mre_pkg::FILE_WR_RESET;
         fileAddr <= mre_pkg::FILE_ADDR_RESET;
         fileData <= mre_pkg::ACC_RESET;
      end else begin
         fileWrEn <= next_fileWrEn;
         fileAddr <= next_fileAddr;
         fileData <= next_fileData;
      end
   end

   // interrupt enable: the return sets it and wins over an interrupt-entry clear in the same cycle
   always_comb begin
      next_globalIntEnable = globalIntEnable;
      if (intCtrlWrEn) begin
         next_globalIntEnable = intCtrlWrData[mre_pkg::GIE_BIT];
      end
      if (gieClear) begin
         next_globalIntEnable = 1'b0;
      end
      if (take && isRetInt) begin
         next_globalIntEnable = 1'b1; // see RQ4
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         globalIntEnable <= mre_pkg::GIE_RESET;
      end else begin
         globalIntEnable <= next_globalIntEnable;
      end
   end
endmodule
`default_nettype wire

// ==== bench/mre_exec_sva.sv ====
// assertion checker for the move-and-return execution block
`timescale 1ns/1ps
`default_nettype none
module mre_exec_sva (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        instrValid,
   input wire logic [13:0] instrWord,
   input wire logic        pushEn,
   input wire logic [12:0] pushAddr,
   input wire logic        gieClear,
   input wire logic        intCtrlWrEn,
   input wire logic [7:0]  intCtrlWrData,
   input wire logic        instrReady,
   input wire logic [7:0]  acc,
   input wire logic [12:0] pc,
   input wire logic        fileWrEn,
   input wire logic [6:0]  fileAddr,
   input wire logic [7:0]  fileData,
   input wire logic        globalIntEnable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic        take = instrValid && instrReady;
   wire logic        quiet = !gieClear && !intCtrlWrEn;
   wire logic [13:0] w = instrWord;
   // a return owns the port for exactly one refused cycle
   sequence s_ret; !instrReady ##1 instrReady; endsequence
   property p_copy; take && (w & 14'h3f80) == 14'h0080
      |=> fileWrEn && fileAddr == $past(w[6:0]) && fileData == $past(acc); endproperty
   a_copy: assert property (p_copy) else $error("file write wrong");
   property p_lit; take && (w & 14'h3c00) == 14'h3000 |=> acc == $past(w[7:0]) && instrReady; endproperty
   a_lit: assert property (p_lit) else $error("literal load wrong");
   property p_rint; take && w == 14'h0009 |=> s_ret; endproperty
   a_rint: assert property (p_rint) else $error("return length wrong");
   property p_gie; take && w == 14'h0009 |=> globalIntEnable; endproperty
   a_gie: assert property (p_gie) else $error("enable not set");
   property p_rlit; take && (w & 14'h3c00) == 14'h3400 |=> acc == $past(w[7:0]) ##0 s_ret; endproperty
   a_rlit: assert property (p_rlit) else $error("literal return wrong");
   property p_rsub; take && w == 14'h0008 && quiet |=> $stable(globalIntEnable) ##0 s_ret; endproperty
   a_rsub: assert property (p_rsub) else $error("plain return wrong");
   property p_idle; take && (w & 14'h3f9f) == 14'h0000
      |=> pc == $past(pc) + 13'h0001 && $stable(acc) && !fileWrEn; endproperty
   a_idle: assert property (p_idle) else $error("idle changed state");
   property p_hold; instrValid && !instrReady |=> $stable(pc) && $stable(acc) && !fileWrEn; endproperty
   a_hold: assert property (p_hold) else $error("refused word acted");
endmodule
bind mre_exec mre_exec_sva i_sva (
   .clk_sys         (clk_sys),
   .rst_n           (rst_n),
   .instrValid      (instrValid),
   .instrWord       (instrWord),
   .pushEn          (pushEn),
   .pushAddr        (pushAddr),
   .gieClear        (gieClear),
   .intCtrlWrEn     (intCtrlWrEn),
   .intCtrlWrData   (intCtrlWrData),
   .instrReady      (instrReady),
   .acc             (acc),
   .pc              (pc),
   .fileWrEn        (fileWrEn),
   .fileAddr        (fileAddr),
   .fileData        (fileData),
   .globalIntEnable (globalIntEnable)
);
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the move-and-return execution block
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        instrValid = 1'b0;
   logic [13:0] instrWord = 14'h0000;
   logic        pushEn = 1'b0;
   logic [12:0] pushAddr = 13'h0000;
   logic        gieClear = 1'b0;
   logic        intCtrlWrEn = 1'b0;
   logic [7:0]  intCtrlWrData = 8'h00;
   logic        instrReady, fileWrEn, globalIntEnable;
   logic [7:0]  acc, fileData;
   logic [12:0] pc;
   logic [6:0]  fileAddr;
   int          bad_count = 0;
   int          num_checks = 0;
   always #20 clk_sys = ~clk_sys;
   mre_exec i_dut (
      .clk_sys         (clk_sys),
      .rst_n           (rst_n),
      .instrValid      (instrValid),
      .instrWord       (instrWord),
      .pushEn          (pushEn),
      .pushAddr        (pushAddr),
      .gieClear        (gieClear),
      .intCtrlWrEn     (intCtrlWrEn),
      .intCtrlWrData   (intCtrlWrData),
      .instrReady      (instrReady),
      .acc             (acc),
      .pc              (pc),
      .fileWrEn        (fileWrEn),
      .fileAddr        (fileAddr),
      .fileData        (fileData),
      .globalIntEnable (globalIntEnable)
   );
   task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // called at an edge; returns at the next edge, whether or not that edge takes the word
   task automatic step(input logic [13:0] word);
      instrValid <= 1'b1;
      instrWord <= word;
      @(posedge clk_sys);
   endtask
   // released word is scrambled so a stale value cannot pass as a new one
   task automatic look();
      instrValid <= 1'b0;
      instrWord <= ~instrWord;
      #1;
   endtask
   task automatic push(input logic [12:0] a);
      @(posedge clk_sys);
      pushEn <= 1'b1;
      pushAddr <= a;
      @(posedge clk_sys);
      pushEn <= 1'b0;
      pushAddr <= ~a;
   endtask
   task automatic t_moves();
      @(posedge clk_sys);
      step(14'h30ff);
      step(14'h00ff);
      look();
      check("wr", fileWrEn, 13'h1);
      check("addr", fileAddr, 13'h7f);
      check("data", fileData, 13'hff);
      check("pc", pc, 13'h2);
      @(posedge clk_sys);
      step(14'h0000);
      step(14'h0100);
      step(14'h325a);
      look();
      check("acc", acc, 13'h5a);
      check("pc", pc, 13'h5);
      check("wr", fileWrEn, 13'h0);
   endtask
   task automatic t_returns();
      push(13'h1abc);
      push(13'h0123);
      push(13'h0555);
      step(14'h34a5);
      #1;
      check("rdy", instrReady, 13'h0);
      // a held word is refused in the second cycle and leaves no trace, then is taken
      step(14'h3011);
      #1;
      check("pc", pc, 13'h0555);
      check("acc", acc, 13'ha5);
      check("rdy", instrReady, 13'h1);
      step(14'h3011);
      look();
      check("acc", acc, 13'h11);
      check("pc", pc, 13'h0556);
      @(posedge clk_sys);
      step(14'h0008);
      look();
      check("pc", pc, 13'h0123);
      check("gie", globalIntEnable, 13'h0);
      check("rdy", instrReady, 13'h0);
      @(posedge clk_sys);
      step(14'h0009);
      look();
      check("pc", pc, 13'h1abc);
      check("gie", globalIntEnable, 13'h1);
      @(posedge clk_sys);
      gieClear <= 1'b1;
      @(posedge clk_sys);
      gieClear <= 1'b0;
      intCtrlWrEn <= 1'b1;
      intCtrlWrData <= 8'h80;
      #1;
      check("gie", globalIntEnable, 13'h0);
      @(posedge clk_sys);
      intCtrlWrEn <= 1'b0;
      #1;
      check("gie", globalIntEnable, 13'h1);
      push(13'h0777);
      // the return's set must win over an interrupt-entry clear at the same edge
      gieClear <= 1'b1;
      step(14'h0009);
      gieClear <= 1'b0;
      look();
      check("pc", pc, 13'h0777);
      check("gie", globalIntEnable, 13'h1);
   endtask
   initial begin
      #100000;
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_moves();
      t_returns();
      repeat (2) @(posedge clk_sys);
      stop_test();
   end
endmodule
`default_nettype wire
